// ===== hw/ppio_pkg.sv
package ppio_pkg;

  // ----------------------------------------------------------------
  // port numbering and widths
  // ----------------------------------------------------------------
  localparam int PORT_W = 8;
  localparam int NPORT = 11;
  localparam logic [3:0] P0 = 4'h0;
  localparam logic [3:0] P1 = 4'h1;
  localparam logic [3:0] P2 = 4'h2;
  localparam logic [3:0] P3 = 4'h3;
  localparam logic [3:0] P5 = 4'h5;
  localparam logic [3:0] P_OD = 4'h6;
  localparam logic [3:0] P7 = 4'h7;
  localparam logic [3:0] P8 = 4'h8;
  localparam logic [3:0] P9 = 4'h9;
  localparam logic [3:0] PA = 4'ha;
  localparam logic [3:0] P_LAST = 4'ha;

  // ----------------------------------------------------------------
  // reset values and bit masks
  // ----------------------------------------------------------------
  localparam logic [7:0] DIR_RST = 8'h00;
  localparam logic [7:0] OD_DIR_RST = 8'hff;
  localparam logic [7:0] DAT_RST = 8'h00;
  localparam logic [7:0] OD_DAT_RST = 8'hff;
  localparam logic [7:0] MASK_FULL = 8'hff;
  localparam logic [7:0] MASK_NONE = 8'h00;
  localparam logic [7:0] MASK_P7 = 8'h7e;
  localparam logic [7:0] MASK_P8 = 8'h7f;
  localparam logic [7:0] MASK_P9 = 8'h3f;
  localparam logic [7:0] MASK_P5_BUS = 8'h3f;
  localparam logic [7:0] MASK_PA_BUS = 8'hfe;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rd;
    logic wr;
    logic rmw;
    logic sel_dir;
    logic [3:0] port;
    logic [7:0] data;
  } ppio_req_t;

  typedef struct packed {
    logic single_chip;
    logic multiplexed;
    logic bus8;
  } ppio_mode_t;

  // bits of a port that exist and belong to the port in this bus mode
  function automatic logic [7:0] port_mask(input logic [3:0] p, input ppio_mode_t m);
    logic [7:0] r;
    r = MASK_FULL;
    unique case (p)
      P0: r = m.single_chip ? MASK_FULL : MASK_NONE;
      P1: r = (m.single_chip || (!m.multiplexed && m.bus8)) ? MASK_FULL : MASK_NONE;
      P2, P3: r = (m.single_chip || m.multiplexed) ? MASK_FULL : MASK_NONE;
      P5: r = m.single_chip ? MASK_FULL : MASK_P5_BUS;
      P7: r = MASK_P7;
      P8: r = MASK_P8;
      P9: r = MASK_P9;
      PA: r = m.single_chip ? MASK_FULL : MASK_PA_BUS;
      4'h4, P_OD: r = MASK_FULL;
      default: r = MASK_NONE;
    endcase
    return r;
  endfunction : port_mask

endpackage : ppio_pkg

// ===== hw/ppio_ports.sv
`timescale 1ns/1ps
module ppio_ports #(
  parameter int PORT_W = ppio_pkg::PORT_W
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire ppio_pkg::ppio_req_t req,
  input wire ppio_pkg::ppio_mode_t mode,
  input wire logic [ppio_pkg::NPORT-1:0][7:0] pin_i,
  output logic [ppio_pkg::NPORT-1:0][7:0] pin_o,
  output logic [ppio_pkg::NPORT-1:0][7:0] pin_oe,
  input wire logic [ppio_pkg::NPORT-1:0][7:0] per_sel,
  input wire logic [ppio_pkg::NPORT-1:0][7:0] per_out,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic [ppio_pkg::NPORT-1:0][7:0] analog_sel
);

  if (PORT_W != 8) begin : g_chk
    $error("ppio_ports serves byte-wide ports only");
  end

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  // two stages so a release near a clock edge never lets some registers
  // leave reset a cycle before the others; entry into reset stays immediate
  logic rst_s1_q;
  logic rst_s1_d;
  logic rst_n;
  logic rst_n_d;
  always_comb begin
    rst_s1_d = 1'b1;
    rst_n_d = rst_s1_q;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= rst_s1_d;
      rst_n <= rst_n_d;
    end
  end

  // ----------------------------------------------------------------
  // masks and pin drive
  // ----------------------------------------------------------------
  logic [ppio_pkg::NPORT-1:0][7:0] dat_q;
  logic [ppio_pkg::NPORT-1:0][7:0] dat_d;
  logic [ppio_pkg::NPORT-1:0][7:0] dir_q;
  logic [ppio_pkg::NPORT-1:0][7:0] dir_d;
  logic [ppio_pkg::NPORT-1:0][7:0] msk;

  always_comb begin
    for (int p = 0; p < ppio_pkg::NPORT; p++) begin
      msk[p] = ppio_pkg::port_mask(4'(p), mode);
      if (4'(p) == ppio_pkg::P_OD) begin
        pin_o[p] = 8'h00;
        pin_oe[p] = msk[p] & ~dir_q[p] & ~dat_q[p];
        analog_sel[p] = dir_q[p];
      end else begin
        pin_o[p] = (per_sel[p] & per_out[p]) | (~per_sel[p] & dat_q[p]);
        pin_oe[p] = msk[p] & (per_sel[p] | dir_q[p]);
        analog_sel[p] = 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // a bit that is absent or lent to the bus reads zero
  function automatic logic [7:0] read_val(input logic [3:0] p, input logic rmw,
                                          input logic [ppio_pkg::NPORT-1:0][7:0] pi,
                                          input logic [ppio_pkg::NPORT-1:0][7:0] ps,
                                          input logic [ppio_pkg::NPORT-1:0][7:0] po,
                                          input logic [ppio_pkg::NPORT-1:0][7:0] dq,
                                          input logic [ppio_pkg::NPORT-1:0][7:0] rq,
                                          input logic [ppio_pkg::NPORT-1:0][7:0] mk);
    logic [7:0] v;
    v = 8'h00;
    if (p <= ppio_pkg::P_LAST) begin
      if (p == ppio_pkg::P_OD) begin
        v = ~rq[p] & (rmw ? dq[p] : pi[p]);
      end else begin
        v = (ps[p] & po[p]) | (~ps[p] & rq[p] & dq[p]) | (~ps[p] & ~rq[p] & pi[p]);
      end
      v = v & mk[p];
    end
    return v;
  endfunction : read_val

  logic [7:0] rd_data_q;
  logic [7:0] rd_data_d;
  logic rd_valid_q;
  logic rd_valid_d;

  always_comb begin
    rd_valid_d = req.rd;
    rd_data_d = rd_data_q;
    if (req.rd) begin
      if (req.sel_dir) begin
        rd_data_d = (req.port <= ppio_pkg::P_LAST) ? (dir_q[req.port] & msk[req.port]) : 8'h00;
      end else begin
        rd_data_d = read_val(req.port, req.rmw, pin_i, per_sel, per_out, dat_q, dir_q, msk);
      end
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // a read-modify-write arrives as its write-back byte; input bits of that byte
  // already carry the pin levels from the read, so the latch takes them
  always_comb begin
    dat_d = dat_q;
    dir_d = dir_q;
    if (req.wr && req.port <= ppio_pkg::P_LAST) begin
      if (req.sel_dir) begin
        dir_d[req.port] = (dir_q[req.port] & ~msk[req.port]) | (req.data & msk[req.port]);
      end else begin
        dat_d[req.port] = (dat_q[req.port] & ~msk[req.port]) | (req.data & msk[req.port]);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int p = 0; p < ppio_pkg::NPORT; p++) begin
        dir_q[p] <= (4'(p) == ppio_pkg::P_OD) ? ppio_pkg::OD_DIR_RST : ppio_pkg::DIR_RST;
        dat_q[p] <= (4'(p) == ppio_pkg::P_OD) ? ppio_pkg::OD_DAT_RST : ppio_pkg::DAT_RST;
      end
    end else begin
      dir_q <= dir_d;
      dat_q <= dat_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_q <= 8'h00;
      rd_valid_q <= 1'b0;
    end else begin
      rd_data_q <= rd_data_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  assign rd_data = rd_data_q;
  assign rd_valid = rd_valid_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_dir_reset: assert property (@(posedge clk) $rose(rst_n) |->
    (dir_q[0] == 8'h00 && dir_q[9] == 8'h00)) else $error("general direction not cleared at reset");
  a_od_dir_reset: assert property (@(posedge clk) $rose(rst_n) |->
    (dir_q[6] == 8'hff && pin_oe[6] == 8'h00)) else $error("open-drain direction not all ones at reset");
  a_in_read_pin: assert property (@(posedge clk) disable iff (!rst_n)
    (req.rd && !req.sel_dir && req.port == 4'h4 && dir_q[4] == 8'h00 && per_sel[4] == 8'h00)
    |=> rd_valid && rd_data == $past(pin_i[4])) else $error("input read not pin level");
  a_out_read_latch: assert property (@(posedge clk) disable iff (!rst_n)
    (req.rd && !req.sel_dir && req.port == 4'h4 && dir_q[4] == 8'hff && per_sel[4] == 8'h00)
    |=> rd_data == $past(dat_q[4])) else $error("output read not latch");
  a_ctrl_read: assert property (@(posedge clk) disable iff (!rst_n)
    (req.rd && !req.sel_dir && req.port == 4'h4)
    |=> ((rd_data ^ $past(per_out[4])) & $past(per_sel[4])) == 8'h00) else $error("control output not read back");
  a_in_no_drive: assert property (@(posedge clk) disable iff (!rst_n)
    ((pin_oe[4] & ~dir_q[4] & ~per_sel[4]) == 8'h00)) else $error("input pin driven");
  a_out_write_pin: assert property (@(posedge clk) disable iff (!rst_n)
    (req.wr && !req.sel_dir && req.port == 4'h4 && dir_q[4] == 8'hff && per_sel[4] == 8'h00)
    ##1 (dir_q[4] == 8'hff && per_sel[4] == 8'h00) |-> pin_o[4] == $past(req.data) && pin_oe[4] == 8'hff)
    else $error("output write not on pin");
  a_od_rmw_latch: assert property (@(posedge clk) disable iff (!rst_n)
    (req.rd && req.rmw && !req.sel_dir && req.port == 4'h6 && dir_q[6] == 8'h00)
    |=> rd_data == $past(dat_q[6])) else $error("open-drain rmw read not latch");
  a_od_plain_pin: assert property (@(posedge clk) disable iff (!rst_n)
    (req.rd && !req.rmw && !req.sel_dir && req.port == 4'h6)
    |=> rd_data == ($past(pin_i[6]) & ~$past(dir_q[6]))) else $error("open-drain plain read not pin");
  a_od_pull_low: assert property (@(posedge clk) disable iff (!rst_n)
    (req.wr && !req.sel_dir && req.port == 4'h6 && dir_q[6] == 8'h00)
    |=> dir_q[6] != 8'h00 || (pin_oe[6] == ~$past(req.data) && pin_o[6] == 8'h00))
    else $error("open-drain write not on pin");
  a_od_analog_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (req.rd && !req.sel_dir && req.port == 4'h6 && dir_q[6] == 8'hff) |=> rd_data == 8'h00)
    else $error("analog bit not read as zero");
  a_unimpl_bits: assert property (@(posedge clk) disable iff (!rst_n)
    (dir_q[7][0] == 1'b0 && dir_q[7][7] == 1'b0 && dir_q[8][7] == 1'b0 && dir_q[9][7:6] == 2'b00
     && pin_oe[7][0] == 1'b0 && pin_oe[9][7:6] == 2'b00)) else $error("absent bit implemented");
  a_p0_bus_mode: assert property (@(posedge clk) disable iff (!rst_n)
    !mode.single_chip |-> pin_oe[0] == 8'h00) else $error("port 0 driven outside single-chip");
  a_p1_bus_mode: assert property (@(posedge clk) disable iff (!rst_n)
    (!mode.single_chip && (mode.multiplexed || !mode.bus8)) |-> pin_oe[1] == 8'h00)
    else $error("port 1 driven in bus mode");
  a_p23_bus_mode: assert property (@(posedge clk) disable iff (!rst_n)
    (!mode.single_chip && !mode.multiplexed) |-> (pin_oe[2] | pin_oe[3]) == 8'h00)
    else $error("port 2 or 3 driven in non-multiplexed mode");
  a_p5a_bus_mode: assert property (@(posedge clk) disable iff (!rst_n)
    !mode.single_chip |-> pin_oe[5][7:6] == 2'b00 && pin_oe[10][0] == 1'b0)
    else $error("single-chip-only bit driven");

  // ----------------------------------------------------------------
  // register and pin checks
  // ----------------------------------------------------------------
  a_rd_valid_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    rd_valid == $past(req.rd))
    else $error("read valid not one cycle after the request");
  a_rd_data_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !$past(req.rd) |-> $stable(rd_data))
    else $error("read data moved without a read");
  a_dat_write: assert property (@(posedge clk) disable iff (!rst_n)
    (req.wr && !req.sel_dir && req.port == 4'h4) |=> dat_q[4] == $past(req.data))
    else $error("data latch write lost");
  a_dir_write: assert property (@(posedge clk) disable iff (!rst_n)
    (req.wr && req.sel_dir && req.port == 4'h4) |=> dir_q[4] == $past(req.data))
    else $error("direction write lost");
  a_in_write_latch: assert property (@(posedge clk) disable iff (!rst_n)
    (req.wr && !req.sel_dir && req.port == 4'h4 && dir_q[4] == 8'h00)
    |=> (pin_oe[4] & ~per_sel[4]) == 8'h00) else $error("input-mode write reached the pin");
  a_oe_by_dir: assert property (@(posedge clk) disable iff (!rst_n)
    (pin_oe[4] & ~per_sel[4]) == (dir_q[4] & ~per_sel[4]))
    else $error("direction bit not on output enable");
  a_out_drive_latch: assert property (@(posedge clk) disable iff (!rst_n)
    ((pin_o[4] ^ dat_q[4]) & ~per_sel[4]) == 8'h00)
    else $error("latch not on unclaimed pin");
  a_ctrl_drive: assert property (@(posedge clk) disable iff (!rst_n)
    ((pin_o[4] ^ per_out[4]) & per_sel[4]) == 8'h00 && (per_sel[4] & ~pin_oe[4]) == 8'h00)
    else $error("control output not on claimed pin");
  a_rmw_in_pin: assert property (@(posedge clk) disable iff (!rst_n)
    (req.rd && req.rmw && !req.sel_dir && req.port == 4'h4 && per_sel[4] == 8'h00)
    |=> ((rd_data ^ $past(pin_i[4])) & ~$past(dir_q[4])) == 8'h00) else $error("rmw read of input bit not pin");
  a_rmw_out_latch: assert property (@(posedge clk) disable iff (!rst_n)
    (req.rd && req.rmw && !req.sel_dir && req.port == 4'h4 && per_sel[4] == 8'h00)
    |=> ((rd_data ^ $past(dat_q[4])) & $past(dir_q[4])) == 8'h00) else $error("rmw read of output bit not latch");
  a_od_drive_zero: assert property (@(posedge clk) disable iff (!rst_n)
    pin_o[6] == 8'h00 && (pin_oe[6] & dat_q[6]) == 8'h00)
    else $error("open-drain pin driven high or released bit pulled");
  a_od_analog_oe: assert property (@(posedge clk) disable iff (!rst_n)
    analog_sel[6] == dir_q[6] && (pin_oe[6] & dir_q[6]) == 8'h00)
    else $error("analog bit not released");
  a_gen_no_analog: assert property (@(posedge clk) disable iff (!rst_n)
    analog_sel[4] == 8'h00 && analog_sel[10] == 8'h00)
    else $error("general port marked analog");
  a_od_dir_write: assert property (@(posedge clk) disable iff (!rst_n)
    (req.wr && req.sel_dir && req.port == 4'h6) |=> dir_q[6] == $past(req.data))
    else $error("open-drain direction write lost");

  // ----------------------------------------------------------------
  // absent-bit, bus-mode and unmapped-port checks
  // ----------------------------------------------------------------
  a_p7_read_absent: assert property (@(posedge clk) disable iff (!rst_n)
    (req.rd && req.port == 4'h7) |=> rd_data[0] == 1'b0 && rd_data[7] == 1'b0)
    else $error("absent port 7 bit read as one");
  a_p8_read_absent: assert property (@(posedge clk) disable iff (!rst_n)
    (req.rd && req.port == 4'h8) |=> rd_data[7] == 1'b0)
    else $error("absent port 8 bit read as one");
  a_p9_read_absent: assert property (@(posedge clk) disable iff (!rst_n)
    (req.rd && req.port == 4'h9) |=> rd_data[7:6] == 2'b00)
    else $error("absent port 9 bit read as one");
  a_p0_read_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (req.rd && req.port == 4'h0 && !mode.single_chip) |=> rd_data == 8'h00)
    else $error("port 0 read outside single-chip");
  a_p1_read_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (req.rd && req.port == 4'h1 && !mode.single_chip && (mode.multiplexed || !mode.bus8)) |=> rd_data == 8'h00)
    else $error("port 1 read in bus mode");
  a_p23_read_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (req.rd && (req.port == 4'h2 || req.port == 4'h3) && !mode.single_chip && !mode.multiplexed) |=> rd_data == 8'h00)
    else $error("port 2 or 3 read in non-multiplexed mode");
  a_p5_read_bits: assert property (@(posedge clk) disable iff (!rst_n)
    (req.rd && req.port == 4'h5 && !mode.single_chip) |=> rd_data[7:6] == 2'b00)
    else $error("port 5 bus bit read outside single-chip");
  a_pa_read_bit: assert property (@(posedge clk) disable iff (!rst_n)
    (req.rd && req.port == 4'ha && !mode.single_chip) |=> rd_data[0] == 1'b0)
    else $error("port A bus bit read outside single-chip");
  a_bus_bits_kept: assert property (@(posedge clk) disable iff (!rst_n)
    (req.wr && req.sel_dir && req.port == 4'h5 && !mode.single_chip) |=> dir_q[5][7:6] == $past(dir_q[5][7:6]))
    else $error("bus-owned direction bit written");
  a_oor_read_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (req.rd && req.port > ppio_pkg::P_LAST) |=> rd_data == 8'h00)
    else $error("unmapped port read not zero");
  a_oor_write: assert property (@(posedge clk) disable iff (!rst_n)
    (req.wr && req.port > ppio_pkg::P_LAST) |=> $stable(dat_q) && $stable(dir_q))
    else $error("write to an unmapped port changed a register");

endmodule : ppio_ports

// ===== verification/ppio_pin_model.sv
`timescale 1ns/1ps
module ppio_pin_model (
  input wire logic clk,
  input wire logic [ppio_pkg::NPORT-1:0][7:0] pin_o,
  input wire logic [ppio_pkg::NPORT-1:0][7:0] pin_oe,
  input wire logic [ppio_pkg::NPORT-1:0][7:0] ext_val,
  input wire logic [ppio_pkg::NPORT-1:0][7:0] ext_en,
  output logic [ppio_pkg::NPORT-1:0][7:0] pin_i
);
  logic tgl_q;
  initial tgl_q = 1'b0;
  always @(posedge clk) begin
    tgl_q <= ~tgl_q;
  end
  always_comb begin
    for (int p = 0; p < ppio_pkg::NPORT; p++) begin
      for (int b = 0; b < 8; b++) begin
        if (p == int'(ppio_pkg::P_OD)) begin
          pin_i[p][b] = pin_oe[p][b] ? 1'b0 : (ext_en[p][b] ? ext_val[p][b] : 1'b1);
        end else if (pin_oe[p][b]) begin
          pin_i[p][b] = pin_o[p][b];
        end else begin
          // floating pin wanders, so a stale level never reads as correct
          pin_i[p][b] = ext_en[p][b] ? ext_val[p][b] : (tgl_q ^ b[0]);
        end
      end
    end
  end
endmodule : ppio_pin_model

// ===== verification/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk;
  logic arst_n;
  ppio_pkg::ppio_req_t req;
  ppio_pkg::ppio_mode_t mode;
  logic [ppio_pkg::NPORT-1:0][7:0] pin_i, pin_o, pin_oe, per_sel, per_out, analog_sel, ext_val, ext_en;
  logic [7:0] rd_data;
  logic rd_valid;
  int n_errors;
  int n_checks;

  ppio_ports dut (.clk(clk), .arst_n(arst_n), .req(req), .mode(mode), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe(pin_oe), .per_sel(per_sel), .per_out(per_out), .rd_data(rd_data), .rd_valid(rd_valid),
    .analog_sel(analog_sel));
  ppio_pin_model pins (.clk(clk), .pin_o(pin_o), .pin_oe(pin_oe), .ext_val(ext_val), .ext_en(ext_en),
    .pin_i(pin_i));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk8

  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  // request held from one falling edge to the next, so it is taken on the rising edge between
  task automatic wr(input logic [3:0] p, input logic dir, input logic [7:0] d, input logic rmw);
    @(negedge clk);
    req = '{rd: 1'b0, wr: 1'b1, rmw: rmw, sel_dir: dir, port: p, data: d};
  endtask : wr

  task automatic idle();
    @(negedge clk);
    req = '0;
  endtask : idle

  task automatic rd(input logic [3:0] p, input logic dir, input logic rmw, input logic [7:0] exp);
    @(negedge clk);
    req = '{rd: 1'b1, wr: 1'b0, rmw: rmw, sel_dir: dir, port: p, data: 8'h00};
    @(negedge clk);
    req = '0;
    chk8({7'h00, rd_valid}, 8'h01, "read valid");
    chk8(rd_data, exp, "read data");
  endtask : rd

  task automatic t_reset();
    rd(4'h4, 1'b1, 1'b0, 8'h00);
    chk8(pin_oe[4], 8'h00, "oe after reset");
    chk8(analog_sel[6], 8'hff, "od dir reset");
  endtask : t_reset

  task automatic t_general();
    ext_en[4] = 8'hff;
    ext_val[4] = 8'ha5;
    wr(4'h4, 1'b0, 8'h3c, 1'b0);
    idle();
    chk8(pin_oe[4], 8'h00, "input not driven");
    rd(4'h4, 1'b0, 1'b0, 8'ha5);
    ext_en[4] = 8'hf0;
    wr(4'h4, 1'b1, 8'h0f, 1'b0);
    idle();
    chk8(pin_oe[4], 8'h0f, "oe by dir");
    chk8(pin_o[4] & 8'h0f, 8'h0c, "latch driven");
    rd(4'h4, 1'b0, 1'b0, 8'hac);
    rd(4'h4, 1'b0, 1'b1, 8'hac);
    wr(4'h4, 1'b0, 8'had, 1'b1);
    ext_en[4] = 8'h00;
    wr(4'h4, 1'b1, 8'hff, 1'b0);
    idle();
    rd(4'h4, 1'b0, 1'b0, 8'had);
    chk8(pin_o[4], 8'had, "output value");
    per_sel[4] = 8'h01;
    rd(4'h4, 1'b0, 1'b0, 8'hac);
    per_sel[4] = 8'h00;
    wr(4'h4, 1'b0, 8'h11, 1'b0);
    wr(4'h4, 1'b0, 8'h22, 1'b0);
    wr(4'hc, 1'b0, 8'h55, 1'b0);
    rd(4'h4, 1'b0, 1'b0, 8'h22);
    rd(4'hc, 1'b0, 1'b0, 8'h00);
  endtask : t_general

  task automatic t_open_drain();
    rd(4'h6, 1'b0, 1'b0, 8'h00);
    wr(4'h6, 1'b1, 8'h00, 1'b0);
    wr(4'h6, 1'b0, 8'hff, 1'b0);
    ext_en[6] = 8'h01;
    idle();
    rd(4'h6, 1'b0, 1'b0, 8'hfe);
    rd(4'h6, 1'b0, 1'b1, 8'hff);
    ext_en[6] = 8'h00;
    wr(4'h6, 1'b0, 8'hfe, 1'b0);
    idle();
    chk8(pin_oe[6], 8'h01, "od pull low");
    rd(4'h6, 1'b0, 1'b0, 8'hfe);
    wr(4'h6, 1'b1, 8'h80, 1'b0);
    idle();
    chk8(analog_sel[6], 8'h80, "analog select");
    rd(4'h6, 1'b0, 1'b0, 8'h7e);
  endtask : t_open_drain

  function automatic logic [7:0] avail(input int p, input logic sc, input logic mx, input logic b8);
    case (p)
      0: return sc ? 8'hff : 8'h00;
      1: return (sc || (!mx && b8)) ? 8'hff : 8'h00;
      2, 3: return (sc || mx) ? 8'hff : 8'h00;
      5: return sc ? 8'hff : 8'h3f;
      7: return 8'h7e;
      8: return 8'h7f;
      9: return 8'h3f;
      default: return sc ? 8'hff : 8'hfe;
    endcase
  endfunction : avail

  task automatic t_modes();
    int plist[9] = '{0, 1, 2, 3, 5, 10, 7, 8, 9};
    logic [2:0] mtab[3] = '{3'b100, 3'b001, 3'b010};
    logic [7:0] e;
    for (int m = 0; m < 3; m++) begin
      mode = mtab[m];
      for (int i = 0; i < 9; i++) begin
        e = avail(plist[i], mtab[m][2], mtab[m][1], mtab[m][0]);
        wr(plist[i][3:0], 1'b1, 8'hff, 1'b0);
        idle();
        chk8(pin_oe[plist[i]], e, "oe by mode");
        rd(plist[i][3:0], 1'b1, 1'b0, e);
      end
    end
  endtask : t_modes

  initial begin
    #1000000;
    n_errors++;
    report_and_stop();
  end

  initial begin
    n_errors = 0;
    n_checks = 0;
    req = '0;
    mode = 3'b100;
    per_sel = '0;
    per_out = '0;
    ext_val = '0;
    ext_en = '0;
    arst_n = 1'b0;
    repeat (10) @(negedge clk);
    arst_n = 1'b1;
    repeat (2) @(negedge clk);
    t_reset();
    t_general();
    t_open_drain();
    t_modes();
    report_and_stop();
  end
endmodule : tb
